// ===== rtl/pfc_defines.svh
// Addresses, field positions, reset values and timing counts of the pin function block.
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH
`define PFC_ADR_W 8
`define PFC_CFG_ADDR 8'h88
`define PFC_STS_ADDR 8'h50
`define PFC_IEN_ADDR 8'h54
`define PFC_CFG_RST 32'h0000_0000
`define PFC_IRQ_RST 3'h0
`define PFC_LED_LSB 28
`define PFC_POL_LSB 24
`define PFC_EEP_LSB 20
`define PFC_DRV_LSB 16
`define PFC_DIR_LSB 8
`define PFC_OUT_LSB 3
`define PFC_DAT_LSB 0
`define PFC_EEP_EEPROM 3'h0
`define PFC_EEP_GPO34 3'h1
`define PFC_EEP_OUTPUT_THREE_RXDV 3'h3
`define PFC_EEP_TXEN_OUTPUT_FOUR 3'h5
`define PFC_EEP_TXEN_RXDV 3'h6
`define PFC_EEP_CLOCKS 3'h7
`define PFC_CLK_NS 8
`define PFC_IRQ_MIN_NS 40
`define PFC_IRQ_MIN_CYC ((`PFC_IRQ_MIN_NS / `PFC_CLK_NS) + 1)
`define PFC_FILT_W 8
`endif

// ===== rtl/pfc_pkg.sv
// Types shared by the pin function block.
package pfc_pkg;
    typedef enum logic [2:0] {
        pfc_mode_eeprom,
        pfc_mode_gpo34,
        pfc_mode_output_three_rxdv,
        pfc_mode_txen_output_four,
        pfc_mode_txen_rxdv,
        pfc_mode_clocks,
        pfc_mode_reserved
    } pfc_eep_mode_e;

    typedef struct packed {
        logic [2:0] led_select;
        logic [2:0] pin_irq_level;
        logic [2:0] eeprom_pin_select;
        logic [2:0] pin_driver_type;
        logic [2:0] pin_direction;
        logic [1:0] output_only_data;
        logic [2:0] pin_data;
    } pfc_cfg_s;

    typedef struct packed {
        logic tx_en;
        logic rx_dv;
        logic tx_clk;
        logic rx_clk;
    } pfc_mii_s;
endpackage

// ===== rtl/pfc_level_filter.sv
// Pin synchroniser and minimum-width level qualifier for one general I/O input.
`timescale 1ns/1ps
`include "pfc_defines.svh"
module pfc_level_filter #(
    parameter int HOLD_CYC = `PFC_IRQ_MIN_CYC
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic pin_i,
    input wire logic level_hi_i,
    output logic level_o,
    output logic qual_o
);
    logic meta_reg, meta_next, sync_reg, sync_next, qual_reg, qual_next, match;
    logic [`PFC_FILT_W-1:0] cnt_reg, cnt_next;

    always_comb begin
        meta_next = pin_i;
        sync_next = meta_reg;
        match = (sync_reg == level_hi_i);
        if (!match) begin
            cnt_next = '0;
        end else if (cnt_reg == `PFC_FILT_W'(HOLD_CYC)) begin
            cnt_next = cnt_reg;
        end else begin
            cnt_next = cnt_reg + `PFC_FILT_W'(1);
        end
        qual_next = (cnt_next == `PFC_FILT_W'(HOLD_CYC));
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            cnt_reg <= '0;
            qual_reg <= 1'b0;
        end else if (ce_i) begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            cnt_reg <= cnt_next;
            qual_reg <= qual_next;
        end
    end

    assign level_o = sync_reg;
    assign qual_o = qual_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    sequence s_held;
        (match && ce_i) [*6];
    endsequence
    property p_min_width_met;
        s_held |=> qual_o;
    endproperty
    a_min_width_met: assert property (p_min_width_met) else $error("held level not qualified");
    property p_short_rejected;
        (ce_i && !match) |=> !qual_o;
    endproperty
    a_short_rejected: assert property (p_short_rejected) else $error("unheld level qualified");
endmodule

// ===== rtl/pfc_pin_function_config.sv
// Pin function configuration register with general I/O, LED and EEPROM pin muxing.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "pfc_defines.svh"
module pfc_pin_function_config (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`PFC_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2:0] led_i,
    input wire pfc_pkg::pfc_mii_s mii_i,
    input wire logic eep_do_i,
    input wire logic eep_doe_i,
    input wire logic eep_clk_i,
    output logic eep_di_o,
    input wire logic [2:0] pin_data_i,
    output logic [2:0] pin_data_o,
    output logic [2:0] pin_data_oe_o,
    input wire logic eeprom_data_pin_i,
    output logic eeprom_data_pin_o,
    output logic eeprom_data_pin_oe_o,
    output logic eeprom_clock_pin_o,
    output logic eeprom_clock_pin_oe_o,
    output logic irq_o
);
    pfc_pkg::pfc_cfg_s cfg_reg, cfg_next;
    pfc_pkg::pfc_eep_mode_e mode;
    logic [2:0] sts_reg, sts_next, ien_reg, ien_next, pin_level, pin_qual, irq_set;
    logic [31:0] dat_reg, dat_next;
    logic ack_reg, ack_next, irq_reg, irq_next, wb_req;
    logic [2:0] pout_reg, pout_next, poe_reg, poe_next;
    logic edo_reg, edo_next, edoe_reg, edoe_next, eck_reg, eck_next, ecoe_reg, ecoe_next;
    logic edi_meta_reg, edi_meta_next, edi_reg, edi_next;

    function automatic logic [31:0] cfg_to_word(input pfc_pkg::pfc_cfg_s c);
        logic [31:0] w;
        w = '0;
        w[`PFC_LED_LSB +: 3] = c.led_select;
        w[`PFC_POL_LSB +: 3] = c.pin_irq_level;
        w[`PFC_EEP_LSB +: 3] = c.eeprom_pin_select;
        w[`PFC_DRV_LSB +: 3] = c.pin_driver_type;
        w[`PFC_DIR_LSB +: 3] = c.pin_direction;
        w[`PFC_OUT_LSB +: 2] = c.output_only_data;
        w[`PFC_DAT_LSB +: 3] = c.pin_data;
        return w;
    endfunction

    function automatic pfc_pkg::pfc_cfg_s word_to_cfg(input logic [31:0] w);
        pfc_pkg::pfc_cfg_s c;
        c.led_select = w[`PFC_LED_LSB +: 3];
        c.pin_irq_level = w[`PFC_POL_LSB +: 3];
        c.eeprom_pin_select = w[`PFC_EEP_LSB +: 3];
        c.pin_driver_type = w[`PFC_DRV_LSB +: 3];
        c.pin_direction = w[`PFC_DIR_LSB +: 3];
        c.output_only_data = w[`PFC_OUT_LSB +: 2];
        c.pin_data = w[`PFC_DAT_LSB +: 3];
        return c;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                          input logic [3:0] sel);
        logic [31:0] w;
        w = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                w[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return w;
    endfunction

    function automatic pfc_pkg::pfc_eep_mode_e decode_mode(input logic [2:0] f);
        case (f)
            `PFC_EEP_EEPROM: decode_mode = pfc_pkg::pfc_mode_eeprom;
            `PFC_EEP_GPO34: decode_mode = pfc_pkg::pfc_mode_gpo34;
            `PFC_EEP_OUTPUT_THREE_RXDV: decode_mode = pfc_pkg::pfc_mode_output_three_rxdv;
            `PFC_EEP_TXEN_OUTPUT_FOUR: decode_mode = pfc_pkg::pfc_mode_txen_output_four;
            `PFC_EEP_TXEN_RXDV: decode_mode = pfc_pkg::pfc_mode_txen_rxdv;
            `PFC_EEP_CLOCKS: decode_mode = pfc_pkg::pfc_mode_clocks;
            default: decode_mode = pfc_pkg::pfc_mode_reserved;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_filter
            pfc_level_filter #(
                .HOLD_CYC(`PFC_IRQ_MIN_CYC)
            ) u_filter (
                .clk_sys_i(clk_sys_i),
                .resetn_i(resetn_i),
                .ce_i(ce_i),
                .pin_i(pin_data_i[g]),
                .level_hi_i(cfg_reg.pin_irq_level[g]),
                .level_o(pin_level[g]),
                .qual_o(pin_qual[g])
            );
        end
    endgenerate

    // Wishbone slave: one registered answer a cycle after the request, unmapped addresses read zero.
    always_comb begin
        wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
        cfg_next = cfg_reg;
        ien_next = ien_reg;
        dat_next = dat_reg;
        ack_next = 1'b0;
        irq_set = pin_qual & ~cfg_reg.led_select;
        sts_next = sts_reg;
        if (wb_req) begin
            ack_next = 1'b1;
            case (wb_adr_i)
                `PFC_CFG_ADDR: begin
                    dat_next = cfg_to_word(cfg_reg);
                    dat_next[`PFC_DAT_LSB +: 3] = pin_level;
                end
                `PFC_STS_ADDR: dat_next = {29'h0, sts_reg};
                `PFC_IEN_ADDR: dat_next = {29'h0, ien_reg};
                default: dat_next = 32'h0;
            endcase
            if (wb_we_i) begin
                case (wb_adr_i)
                    `PFC_CFG_ADDR: cfg_next = word_to_cfg(merge(cfg_to_word(cfg_reg), wb_dat_i,
                                                                wb_sel_i));
                    `PFC_STS_ADDR: begin
                        if (wb_sel_i[0]) begin
                            sts_next = sts_reg & ~wb_dat_i[2:0];
                        end
                    end
                    `PFC_IEN_ADDR: begin
                        if (wb_sel_i[0]) begin
                            ien_next = wb_dat_i[2:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
        sts_next = sts_next | irq_set;
        irq_next = |(sts_reg & ien_reg);
    end

    // Pin drivers for the three general I/O pins and the two EEPROM pins.
    always_comb begin
        mode = decode_mode(cfg_reg.eeprom_pin_select);
        for (int i = 0; i < 3; i++) begin
            if (cfg_reg.led_select[i]) begin
                pout_next[i] = led_i[i];
                poe_next[i] = 1'b1;
            end else if (cfg_reg.pin_direction[i]) begin
                if (cfg_reg.pin_driver_type[i]) begin
                    pout_next[i] = cfg_reg.pin_data[i];
                    poe_next[i] = 1'b1;
                end else begin
                    pout_next[i] = 1'b0;
                    poe_next[i] = !cfg_reg.pin_data[i];
                end
            end else begin
                pout_next[i] = 1'b0;
                poe_next[i] = 1'b0;
            end
        end
        edo_next = 1'b0;
        edoe_next = 1'b1;
        eck_next = 1'b0;
        ecoe_next = 1'b1;
        case (mode)
            pfc_pkg::pfc_mode_eeprom: begin
                edo_next = eep_do_i;
                edoe_next = eep_doe_i;
                eck_next = eep_clk_i;
            end
            pfc_pkg::pfc_mode_gpo34: begin
                edo_next = cfg_reg.output_only_data[0];
                eck_next = cfg_reg.output_only_data[1];
            end
            pfc_pkg::pfc_mode_output_three_rxdv: begin
                edo_next = cfg_reg.output_only_data[0];
                eck_next = mii_i.rx_dv;
            end
            pfc_pkg::pfc_mode_txen_output_four: begin
                edo_next = mii_i.tx_en;
                eck_next = cfg_reg.output_only_data[1];
            end
            pfc_pkg::pfc_mode_txen_rxdv: begin
                edo_next = mii_i.tx_en;
                eck_next = mii_i.rx_dv;
            end
            pfc_pkg::pfc_mode_clocks: begin
                edo_next = mii_i.tx_clk;
                eck_next = mii_i.rx_clk;
            end
            default: begin
                edoe_next = 1'b0;
                ecoe_next = 1'b0;
            end
        endcase
        edi_meta_next = eeprom_data_pin_i;
        edi_next = edi_meta_reg;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cfg_reg <= word_to_cfg(`PFC_CFG_RST);
            sts_reg <= `PFC_IRQ_RST;
            ien_reg <= `PFC_IRQ_RST;
            dat_reg <= 32'h0;
            ack_reg <= 1'b0;
            irq_reg <= 1'b0;
            pout_reg <= 3'h0;
            poe_reg <= 3'h0;
            edo_reg <= 1'b0;
            edoe_reg <= 1'b0;
            eck_reg <= 1'b0;
            ecoe_reg <= 1'b0;
            edi_meta_reg <= 1'b0;
            edi_reg <= 1'b0;
        end else if (ce_i) begin
            cfg_reg <= cfg_next;
            sts_reg <= sts_next;
            ien_reg <= ien_next;
            dat_reg <= dat_next;
            ack_reg <= ack_next;
            irq_reg <= irq_next;
            pout_reg <= pout_next;
            poe_reg <= poe_next;
            edo_reg <= edo_next;
            edoe_reg <= edoe_next;
            eck_reg <= eck_next;
            ecoe_reg <= ecoe_next;
            edi_meta_reg <= edi_meta_next;
            edi_reg <= edi_next;
        end
    end

    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
    assign irq_o = irq_reg;
    assign pin_data_o = pout_reg;
    assign pin_data_oe_o = poe_reg;
    assign eeprom_data_pin_o = edo_reg;
    assign eeprom_data_pin_oe_o = edoe_reg;
    assign eeprom_clock_pin_o = eck_reg;
    assign eeprom_clock_pin_oe_o = ecoe_reg;
    assign eep_di_o = edi_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    property p_led_drive;
        (ce_i && cfg_reg.led_select[0]) |=> (pin_data_oe_o[0] && pin_data_o[0] == $past(led_i[0]));
    endproperty
    a_led_drive: assert property (p_led_drive) else $error("led pin not driven");
    property p_status_cause;
        $rose(sts_reg[1]) |-> $past(pin_qual[1] && !cfg_reg.led_select[1]);
    endproperty
    a_status_cause: assert property (p_status_cause) else $error("status set without level");
    property p_status_set;
        (ce_i && pin_qual[0] && !cfg_reg.led_select[0]) |=> sts_reg[0];
    endproperty
    a_status_set: assert property (p_status_set) else $error("qualified level lost");
    property p_irq_masked;
        (ce_i && ien_reg == 3'h0) |=> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt raised");
    property p_irq_raised;
        (ce_i && (sts_reg & ien_reg) != 3'h0) |=> irq_o;
    endproperty
    a_irq_raised: assert property (p_irq_raised) else $error("enabled interrupt missing");
    property p_clock_mode;
        (ce_i && cfg_reg.eeprom_pin_select == `PFC_EEP_CLOCKS)
            |=> (eeprom_clock_pin_o == $past(mii_i.rx_clk) && eeprom_data_pin_oe_o);
    endproperty
    a_clock_mode: assert property (p_clock_mode) else $error("clock mode mux wrong");
    property p_open_drain;
        (ce_i && !cfg_reg.led_select[2] && cfg_reg.pin_direction[2]
            && !cfg_reg.pin_driver_type[2] && cfg_reg.pin_data[2]) |=> !pin_data_oe_o[2];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drove high");
    property p_input_released;
        (ce_i && !cfg_reg.led_select[1] && !cfg_reg.pin_direction[1]) |=> !pin_data_oe_o[1];
    endproperty
    a_input_released: assert property (p_input_released) else $error("input pin driven");
    property p_gpo_mode;
        (ce_i && cfg_reg.eeprom_pin_select == `PFC_EEP_GPO34)
            |=> (eeprom_data_pin_o == $past(cfg_reg.output_only_data[0])
                 && eeprom_clock_pin_o == $past(cfg_reg.output_only_data[1]));
    endproperty
    a_gpo_mode: assert property (p_gpo_mode) else $error("output bits not on pins");
    property p_readback;
        (ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == `PFC_CFG_ADDR)
            |=> (wb_ack_o && wb_dat_o[2:0] == $past(pin_level));
    endproperty
    a_readback: assert property (p_readback) else $error("readback not pin level");
endmodule

// ===== testbench/pfc_pin_board.sv
// Board-side model of the pins: pull-ups, external drivers and the serial memory data line.
`timescale 1ns/1ps
module pfc_pin_board (
    input wire logic [2:0] pin_out_i,
    input wire logic [2:0] pin_oe_i,
    input wire logic [2:0] ext_en_i,
    input wire logic [2:0] ext_val_i,
    output logic [2:0] pin_lvl_o,
    input wire logic ee_out_i,
    input wire logic ee_oe_i,
    input wire logic ee_ans_i,
    output logic ee_lvl_o
);
    // A released pin with no external driver enabled is pulled high, so open-drain outputs then read back one when off.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pin_oe_i[i]) begin
                pin_lvl_o[i] = pin_out_i[i];
            end else if (ext_en_i[i]) begin
                pin_lvl_o[i] = ext_val_i[i];
            end else begin
                pin_lvl_o[i] = 1'b1;
            end
        end
        ee_lvl_o = ee_oe_i ? ee_out_i : ee_ans_i;
    end
endmodule

// ===== testbench/pin_function_config_tb_top.sv
// Self-checking testbench of the pin function block.
`timescale 1ns/1ps
`include "pfc_defines.svh"
module pin_function_config_tb_top;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic [2:0] led = 3'h0;
    pfc_pkg::pfc_mii_s mii = 4'h0;
    logic eep_do = 1'b0;
    logic eep_doe = 1'b0;
    logic eep_clk = 1'b0;
    logic eep_di;
    logic [2:0] pin_lvl, pin_out, pin_oe, ext_en = 3'h0, ext_val = 3'h0;
    logic ee_lvl, ee_out, ee_oe, ck_out, ck_oe, irq;
    logic ee_ans = 1'b1;
    int err_total = 0;
    int compares = 0;

    always #4 clk_sys = ~clk_sys;

    pfc_pin_function_config i_dut (.clk_sys_i(clk_sys), .resetn_i(resetn), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .led_i(led), .mii_i(mii),
        .eep_do_i(eep_do), .eep_doe_i(eep_doe), .eep_clk_i(eep_clk), .eep_di_o(eep_di),
        .pin_data_i(pin_lvl), .pin_data_o(pin_out), .pin_data_oe_o(pin_oe),
        .eeprom_data_pin_i(ee_lvl), .eeprom_data_pin_o(ee_out), .eeprom_data_pin_oe_o(ee_oe),
        .eeprom_clock_pin_o(ck_out), .eeprom_clock_pin_oe_o(ck_oe), .irq_o(irq));

    pfc_pin_board i_board (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pin_lvl_o(pin_lvl), .ee_out_i(ee_out), .ee_oe_i(ee_oe),
        .ee_ans_i(ee_ans), .ee_lvl_o(ee_lvl));

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        q = wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk("ack", 32'h1, {31'h0, wb_ack});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, a, 32'h0, q);
        chk(name, exp, q);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    function automatic logic [31:0] cfg(input logic [2:0] l, input logic [2:0] p,
            input logic [2:0] e, input logic [2:0] b, input logic [2:0] r,
            input logic [1:0] o, input logic [2:0] d);
        return {1'b0, l, 1'b0, p, 1'b0, e, 1'b0, b, 5'h0, r, 3'h0, o, d};
    endfunction

    task automatic t_reset();
        chk("oe after reset", 32'h0, {29'h0, pin_oe});
        chk("clock pin oe", 32'h1, {31'h0, ck_oe});
        rd("config reset", `PFC_CFG_ADDR, 32'h7);
        rd("status reset", `PFC_STS_ADDR, 32'h0);
        rd("enable reset", `PFC_IEN_ADDR, 32'h0);
        wr(8'h8c, 32'hffff_ffff);
        rd("unmapped", 8'h8c, 32'h0);
    endtask

    task automatic t_led();
        led <= 3'b101;
        wr(`PFC_CFG_ADDR, 32'hffff_ffff);
        wait_cyc(4);
        chk("led out", 32'h5, {29'h0, pin_out});
        chk("led oe", 32'h7, {29'h0, pin_oe});
        rd("config full", `PFC_CFG_ADDR, 32'h7777_071d);
        led <= 3'b010;
        wait_cyc(4);
        chk("led follow", 32'h2, {29'h0, pin_out});
        ce <= 1'b0;
        led <= 3'b101;
        wait_cyc(4);
        chk("ce freeze", 32'h2, {29'h0, pin_out});
        ce <= 1'b1;
        wait_cyc(3);
        chk("ce resume", 32'h5, {29'h0, pin_out});
    endtask

    task automatic t_gpio();
        wr(`PFC_CFG_ADDR, cfg(3'h0, 3'h0, 3'h0, 3'b011, 3'b111, 2'h0, 3'b010));
        wait_cyc(3);
        chk("push pull out", 32'h2, {29'h0, pin_out});
        chk("drain on oe", 32'h7, {29'h0, pin_oe});
        wr(`PFC_CFG_ADDR, cfg(3'h0, 3'h0, 3'h0, 3'b011, 3'b111, 2'h0, 3'b110));
        wait_cyc(3);
        chk("drain off oe", 32'h3, {29'h0, pin_oe});
        rd("pin level", `PFC_CFG_ADDR, cfg(3'h0, 3'h0, 3'h0, 3'b011, 3'b111, 2'h0, 3'b110));
        ext_val <= 3'b001;
        ext_en <= 3'b111;
        wr(`PFC_CFG_ADDR, 32'h0);
        wait_cyc(3);
        chk("input oe", 32'h0, {29'h0, pin_oe});
        rd("input level", `PFC_CFG_ADDR, 32'h1);
    endtask

    task automatic t_eeprom();
        logic [2:0] modes [6];
        logic [1:0] ed, ck;
        modes = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
        for (int p = 0; p < 2; p++) begin
            mii <= (p == 0) ? 4'b1010 : 4'b0110;
            eep_do <= (p == 0);
            eep_doe <= (p == 0);
            eep_clk <= (p == 1);
            ee_ans <= (p == 1);
            for (int m = 0; m < 6; m++) begin
                // Mode changes only between memory cycles, and only legal codes.
                wr(`PFC_CFG_ADDR, cfg(3'h0, 3'h0, modes[m], 3'h0, 3'h0, 2'(p + 1), 3'h0));
                wait_cyc(4);
                case (modes[m])
                    3'h0: begin ed = {eep_doe, eep_do}; ck = {1'b1, eep_clk}; end
                    3'h1: begin ed = {1'b1, p == 0}; ck = {1'b1, p == 1}; end
                    3'h3: begin ed = {1'b1, p == 0}; ck = {1'b1, mii.rx_dv}; end
                    3'h5: begin ed = {1'b1, mii.tx_en}; ck = {1'b1, p == 1}; end
                    3'h6: begin ed = {1'b1, mii.tx_en}; ck = {1'b1, mii.rx_dv}; end
                    default: begin ed = {1'b1, mii.tx_clk}; ck = {1'b1, mii.rx_clk}; end
                endcase
                chk("data pin", {30'h0, ed}, {30'h0, ee_oe, ee_out});
                chk("clock pin", {30'h0, ck}, {30'h0, ck_oe, ck_out});
            end
        end
        wr(`PFC_CFG_ADDR, 32'h0);
        wait_cyc(5);
        chk("memory data in", 32'h1, {31'h0, eep_di});
        ee_ans <= 1'b0;
        wait_cyc(5);
        chk("memory data low", 32'h0, {31'h0, eep_di});
    endtask

    task automatic t_irq();
        ext_val <= 3'b110;
        wr(`PFC_CFG_ADDR, cfg(3'h0, 3'b001, 3'h0, 3'h0, 3'h0, 2'h0, 3'h0));
        wait_cyc(12);
        wr(`PFC_STS_ADDR, 32'h7);
        rd("status clear", `PFC_STS_ADDR, 32'h0);
        ext_val <= 3'b111;
        wait_cyc(5);
        ext_val <= 3'b110;
        wait_cyc(20);
        rd("short pulse", `PFC_STS_ADDR, 32'h0);
        ext_val <= 3'b111;
        wait_cyc(12);
        ext_val <= 3'b110;
        wait_cyc(12);
        rd("high level", `PFC_STS_ADDR, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`PFC_IEN_ADDR, 32'h1);
        wait_cyc(3);
        chk("irq enabled", 32'h1, {31'h0, irq});
        wr(`PFC_STS_ADDR, 32'h1);
        wait_cyc(3);
        chk("irq cleared", 32'h0, {31'h0, irq});
        ext_val <= 3'b100;
        wait_cyc(12);
        ext_val <= 3'b110;
        wait_cyc(12);
        rd("low level", `PFC_STS_ADDR, 32'h2);
        chk("irq other masked", 32'h0, {31'h0, irq});
    endtask

    initial begin
        wait_cyc(16);
        resetn <= 1'b1;
        wait_cyc(2);
        t_reset();
        t_led();
        t_gpio();
        t_eeprom();
        t_irq();
        test_done();
    end

    initial begin
        wait_cyc(20000);
        err_total++;
        test_done();
    end
endmodule
